/* File: verilog/pin_ctrl_pkg.sv */
package pin_ctrl_pkg;
  // ----------------------------------------
  // Clocking and timing
  // ----------------------------------------
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int RTC_FREQ_HZ = 32_768;
  localparam int TICK_DIV = CLK_FREQ_HZ / RTC_FREQ_HZ;
  localparam int TICK_CNT_W = 9;
  localparam int GR_HOLD_S = 12;
  localparam int GR_HOLD_TICKS = GR_HOLD_S * RTC_FREQ_HZ;
  localparam int HOLD_CNT_W = 20;
  localparam int SEQ_PHASE_CYCLES = 16;
  localparam int SEQ_CNT_W = 5;
  // ----------------------------------------
  // Pins and widths
  // ----------------------------------------
  localparam int NUM_KEYS = 3;
  localparam int GR_KEY_IDX = 2;
  localparam int IRQ_W = 24;
  localparam logic GR_SEL_RESET = 1'b0;
  localparam logic [NUM_KEYS-1:0] KEYS_IDLE = 3'h7;
  // ----------------------------------------
  // Strap, ID and touch encodings
  // ----------------------------------------
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_DIGCORE = 2'h1;
  localparam logic [1:0] STRAP_CORE = 2'h2;
  localparam logic [1:0] UID_FLOAT = 2'h0;
  localparam logic [1:0] UID_GROUND = 2'h1;
  localparam logic [1:0] UID_FACTORY = 2'h2;
  localparam logic [1:0] TS_INACTIVE = 2'h0;
  localparam logic [1:0] TS_INTERRUPT = 2'h1;
  localparam logic [2:0] ADC_CH_FIRST_PLATE = 3'h4;
  localparam logic [2:0] ADC_CH_LIGHT = 3'h7;
  // ----------------------------------------
  // Global reset sequence
  // ----------------------------------------
  typedef enum logic [1:0] {ST_ON, ST_DOWN, ST_LOAD, ST_UP} gr_state_t;
endpackage

/* File: verilog/edge_if.sv */
`timescale 1ns/1ns
interface edge_if #(parameter int W = 1);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  // Raw pins and synchronised view
  input wire logic [W-1:0] pin,
  edge_if.src sig
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
    end
    else if (ce && en)
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Edges stand until the next enabled cycle
  assign sig.level = s2;
  assign sig.rise = s2 & ~s3;
  assign sig.fall = ~s2 & s3;
endmodule

/* File: verilog/press_timer.sv */
`timescale 1ns/1ns
module press_timer
  import pin_ctrl_pkg::*;
#(
  parameter int HOLD = GR_HOLD_TICKS,
  parameter int IDX = GR_KEY_IDX
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  // Synchronised keys
  edge_if.dst keys,
  // Release classification
  output logic long_held,
  output logic rel_long,
  output logic rel_short
);
  logic [HOLD_CNT_W-1:0] hold_cnt;
  wire pressed = !keys.level[IDX];
  wire saturated = &hold_cnt;
  wire over_hold = hold_cnt > HOLD_CNT_W'(HOLD);
  wire released = tick && keys.rise[IDX];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt <= '0;
      long_held <= 1'b0;
      rel_long <= 1'b0;
      rel_short <= 1'b0;
    end
    else if (ce)
    begin
      if (tick)
        hold_cnt <= pressed ? (saturated ? hold_cnt : hold_cnt + 1'b1) : '0;
      long_held <= over_hold;
      rel_long <= released && over_hold;
      rel_short <= released && !over_hold;
    end
  end
endmodule

/* File: verilog/pmic_control_pin_logic.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Alert high while unmasked interrupt pending.
// - Pulled-down turn-on input counts as key press.
// - Global reset select bit resets to zero.
// - Active-low variant: zero enables global reset.
// - Active-high variant: one enables global reset.
// - Select bit writable in every state except ST_LOAD, which restores default.
// - Global reset: down, charger off, defaults, up.
// - Global reset only after hold over 12s, release.
// - Shorter low pulse is plain turn-on event.
// - Power-up select straps choose start-up supplies.
// - Mode strap: ground, digital core, core decode.
// - Chip select low at cold start: SPI.
// - Chip select high at cold start: I2C, ignored.
// - Weak pull-down on chip select; host holds low.
// - I2C uses clock pin and read pin.
// - Write pin strap gives I2C address bit.
// - USB ID floating, grounded, factory sense bits.
// - Source bit set connects bus power to regulator.
// - Inactive touch plates are ADC channels 4-7.
// - Touch interrupt mode biases X, grounds Y.
// - Rising trigger edge starts ADC conversion.
// - Channel 7 offers second input on output four.
module pmic_control_pin_logic #(
  parameter bit GR_PRESENT = 1'b1,
  parameter bit ACTIVE_LOW_SEL = 1'b1,
  parameter int HOLD_TICKS = pin_ctrl_pkg::GR_HOLD_TICKS,
  parameter int SEQ_CYCLES = pin_ctrl_pkg::SEQ_PHASE_CYCLES
)(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Interrupt to processor
  input wire logic [pin_ctrl_pkg::IRQ_W-1:0] irq_pending,
  input wire logic [pin_ctrl_pkg::IRQ_W-1:0] irq_mask,
  output logic alert,
  // Turn-on keys
  input wire logic [pin_ctrl_pkg::NUM_KEYS-1:0] turn_on_key_inputs,
  output logic turn_on_event,
  // Global reset
  input wire logic global_reset_select_wr,
  input wire logic global_reset_select_wdata,
  output logic global_reset_select_bit,
  output logic power_on,
  output logic charger_allowed,
  output logic registers_to_default,
  // Start-up straps
  input wire logic power_up_select_pin_one,
  input wire logic power_up_select_pin_two,
  input wire logic [1:0] mode_strap_level,
  output logic [1:0] power_up_select,
  output logic mode_normal,
  output logic mode_usb_lp_boot,
  output logic mode_test,
  // Host interface pins
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic miso_pin_in,
  output logic miso_pin_out,
  output logic miso_pin_oe,
  output logic cs_pulldown_en,
  output logic host_if_i2c,
  output logic i2c_addr_a0,
  // Serial cores
  input wire logic spi_miso_data,
  input wire logic spi_miso_drive,
  input wire logic i2c_sda_drive,
  output logic spi_cs,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic i2c_scl,
  output logic i2c_sda_in,
  // USB
  input wire logic [1:0] usb_id_level,
  input wire logic usb_regulator_source_bit,
  output logic usb_id_floating,
  output logic usb_id_grounded,
  output logic usb_id_factory,
  output logic usb_bus_power_switch,
  // Touch screen and ADC
  input wire logic [1:0] ts_mode,
  input wire logic [2:0] adc_channel,
  input wire logic general_output_four_adc_select,
  input wire logic conversion_trigger_pin,
  output logic [3:0] ts_plate_to_adc,
  output logic second_light_sensor_input,
  output logic ts_x_bias_en,
  output logic ts_y_ground_en,
  output logic adc_start
);
  import pin_ctrl_pkg::*;

  // ----------------------------------------
  // 32k tick
  // ----------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic tick;
  wire tick_wrap = tick_cnt == TICK_CNT_W'(TICK_DIV - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      tick <= tick_wrap;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and press timer
  // ----------------------------------------
  edge_if #(.W(NUM_KEYS)) key_sig();
  edge_if #(.W(1)) trig_sig();
  logic long_held;
  logic rel_long;
  logic rel_short;

  pin_sync #(.W(NUM_KEYS), .IDLE(KEYS_IDLE)) u_key_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .en(tick),
    .pin(turn_on_key_inputs),
    .sig(key_sig.src)
  );

  pin_sync #(.W(1), .IDLE(1'b0)) u_trig_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .en(1'b1),
    .pin(conversion_trigger_pin),
    .sig(trig_sig.src)
  );

  press_timer #(.HOLD(HOLD_TICKS), .IDX(GR_KEY_IDX)) u_press (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .keys(key_sig.dst),
    .long_held(long_held),
    .rel_long(rel_long),
    .rel_short(rel_short)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  gr_state_t state;
  gr_state_t next_state;
  logic [SEQ_CNT_W-1:0] seq_cnt;
  logic strap_done;
  wire phase_done = seq_cnt == SEQ_CNT_W'(SEQ_CYCLES - 1);
  wire gr_armed = GR_PRESENT && (ACTIVE_LOW_SEL ? !global_reset_select_bit : global_reset_select_bit);
  wire gr_fire = rel_long && gr_armed;
  wire key_press = tick && |key_sig.fall;
  wire strap_latch = !strap_done || state == ST_LOAD;
  wire next_alert = |(irq_pending & ~irq_mask);
  wire light2_sel = general_output_four_adc_select && adc_channel == ADC_CH_LIGHT;
  wire plates_free = ts_mode == TS_INACTIVE && adc_channel >= ADC_CH_FIRST_PLATE;
  wire [3:0] next_plate = (plates_free && !light2_sel) ? 4'h1 << adc_channel[1:0] : 4'h0;
  wire ts_int = ts_mode == TS_INTERRUPT;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_ON: if (gr_fire) next_state = ST_DOWN;
      ST_DOWN: if (phase_done) next_state = ST_LOAD;
      ST_LOAD: next_state = ST_UP;
      ST_UP: if (phase_done) next_state = ST_ON;
    endcase
  end

  // ----------------------------------------
  // Global reset sequence
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_ON;
      seq_cnt <= '0;
      power_on <= 1'b1;
      charger_allowed <= 1'b1;
      registers_to_default <= 1'b0;
      global_reset_select_bit <= GR_SEL_RESET;
    end
    else if (ce)
    begin
      state <= next_state;
      seq_cnt <= (next_state != state) ? '0 : seq_cnt + 1'b1;
      power_on <= next_state == ST_ON || next_state == ST_UP;
      charger_allowed <= next_state == ST_ON;
      registers_to_default <= next_state == ST_LOAD;
      if (state == ST_LOAD)
        global_reset_select_bit <= GR_SEL_RESET;
      else if (global_reset_select_wr)
        global_reset_select_bit <= global_reset_select_wdata;
    end
  end

  // ----------------------------------------
  // Cold-start straps
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done <= 1'b0;
      power_up_select <= 2'h0;
      mode_normal <= 1'b1;
      mode_usb_lp_boot <= 1'b0;
      mode_test <= 1'b0;
      host_if_i2c <= 1'b0;
      i2c_addr_a0 <= 1'b0;
    end
    else if (ce && strap_latch)
    begin
      strap_done <= 1'b1;
      power_up_select <= {power_up_select_pin_two, power_up_select_pin_one};
      mode_normal <= mode_strap_level == STRAP_GND;
      mode_usb_lp_boot <= mode_strap_level == STRAP_DIGCORE;
      mode_test <= mode_strap_level == STRAP_CORE;
      host_if_i2c <= cs_pin;
      i2c_addr_a0 <= mosi_pin;
    end
  end

  // ----------------------------------------
  // Host pin routing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_pulldown_en <= 1'b0;
      spi_cs <= 1'b0;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
      i2c_scl <= 1'b1;
      i2c_sda_in <= 1'b1;
      miso_pin_out <= 1'b0;
      miso_pin_oe <= 1'b0;
    end
    else if (ce)
    begin
      cs_pulldown_en <= 1'b1;
      spi_cs <= !host_if_i2c && cs_pin;
      spi_sclk <= !host_if_i2c && sclk_pin;
      spi_mosi <= !host_if_i2c && mosi_pin;
      i2c_scl <= host_if_i2c ? sclk_pin : 1'b1;
      i2c_sda_in <= host_if_i2c ? miso_pin_in : 1'b1;
      miso_pin_out <= host_if_i2c ? 1'b0 : spi_miso_data;
      miso_pin_oe <= host_if_i2c ? i2c_sda_drive : spi_miso_drive;
    end
  end

  // ----------------------------------------
  // Alert, events, USB and touch screen
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert <= 1'b0;
      turn_on_event <= 1'b0;
      adc_start <= 1'b0;
      usb_id_floating <= 1'b0;
      usb_id_grounded <= 1'b0;
      usb_id_factory <= 1'b0;
      usb_bus_power_switch <= 1'b0;
      ts_plate_to_adc <= 4'h0;
      second_light_sensor_input <= 1'b0;
      ts_x_bias_en <= 1'b0;
      ts_y_ground_en <= 1'b0;
    end
    else if (ce)
    begin
      alert <= next_alert;
      turn_on_event <= key_press;
      adc_start <= trig_sig.rise[0];
      usb_id_floating <= usb_id_level == UID_FLOAT;
      usb_id_grounded <= usb_id_level == UID_GROUND;
      usb_id_factory <= usb_id_level == UID_FACTORY;
      usb_bus_power_switch <= usb_regulator_source_bit;
      ts_plate_to_adc <= next_plate;
      second_light_sensor_input <= light2_sel;
      ts_x_bias_en <= ts_int;
      ts_y_ground_en <= ts_int;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ALERT: assert property (ce && |(irq_pending & ~irq_mask) |=> alert)
    else $error("alert not raised for pending event");
  AST_KEY_EVENT: assert property (ce && tick && |key_sig.fall |=> turn_on_event)
    else $error("key press gave no turn-on event");
  AST_SEL_DEFAULT: assert property (ce && state == ST_LOAD |=> !global_reset_select_bit)
    else $error("select bit not back to default");
  AST_GR_LOW: assert property (ACTIVE_LOW_SEL && GR_PRESENT && ce && state == ST_ON && rel_long
    && !global_reset_select_bit |=> state == ST_DOWN)
    else $error("active-low variant missed global reset");
  AST_GR_HIGH: assert property (!ACTIVE_LOW_SEL && GR_PRESENT && ce && state == ST_ON && rel_long
    |=> (state == ST_DOWN) == $past(global_reset_select_bit))
    else $error("active-high variant select ignored");
  AST_SEL_WRITE: assert property (ce && global_reset_select_wr && state != ST_LOAD
    |=> global_reset_select_bit == $past(global_reset_select_wdata))
    else $error("select bit write lost");
  AST_SEQ_DOWN: assert property ($rose(registers_to_default) |-> !power_on && !charger_allowed)
    else $error("defaults loaded while powered");
  AST_GR_CAUSE: assert property (state == ST_ON ##1 state == ST_DOWN |-> $past(rel_long) && $past(long_held))
    else $error("global reset without long press");
  AST_SHORT: assert property (ce && rel_short && state == ST_ON |=> state == ST_ON)
    else $error("short press caused global reset");
  AST_BUS_MODE: assert property (ce && strap_latch |=> host_if_i2c == $past(cs_pin))
    else $error("bus mode not latched from chip select");
  AST_CS_IGNORED: assert property (ce && host_if_i2c |=> !spi_cs)
    else $error("chip select used in I2C mode");
  AST_SDA: assert property (ce && host_if_i2c && $stable(host_if_i2c)
    |=> miso_pin_oe == $past(i2c_sda_drive) && !miso_pin_out)
    else $error("SDA drive not routed");
  AST_TRIG: assert property (ce && trig_sig.rise[0] |=> adc_start)
    else $error("trigger edge gave no conversion");
  AST_TS_INT: assert property (ce && ts_mode == TS_INTERRUPT |=> ts_x_bias_en && ts_y_ground_en)
    else $error("touch interrupt bias missing");

  COV_GLOBAL_RESET: cover property (state == ST_ON ##1 state == ST_DOWN);
  COV_SHORT_PRESS: cover property (rel_short ##1 state == ST_ON);
  COV_I2C_MODE: cover property (strap_done && host_if_i2c);
  COV_ADC_START: cover property (adc_start);
endmodule

/* File: verif/host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Processor side: keys, chip select, data line
// ----------------------------------------
module host_model
  import pin_ctrl_pkg::*;
(
  // Requests from bench
  input wire logic [pin_ctrl_pkg::NUM_KEYS-1:0] press,
  input wire logic cs_drive,
  input wire logic sda_low,
  // Device data pin
  input wire logic miso_pin_out,
  input wire logic miso_pin_oe,
  // Pins seen by device
  output logic [pin_ctrl_pkg::NUM_KEYS-1:0] keys,
  output logic cs_pin,
  output logic miso_pin_in
);
  // Open-drain pull-down per key, pull-up when released
  assign keys = ~press;
  // Held low through turn-on unless I2C strap wanted
  assign cs_pin = cs_drive;
  // Shared data line with pull-up
  assign miso_pin_in = miso_pin_oe ? miso_pin_out : ~sda_low;
endmodule

/* File: verif/pmic_control_pin_logic_tb.sv */
`timescale 1ns/1ns
module pmic_control_pin_logic_tb;
  import pin_ctrl_pkg::*;
  localparam int P_HOLD = 20;
  localparam int P_SEQ = 16;
  localparam int DLY = 5;
  typedef struct {int id; string name; logic [23:0] exp;} note_t;
  note_t note_q[$];
  note_t cur;
  int fail_count = 0;
  int checked = 0;
  int ev_count = 0;
  int down_count = 0;
  int e0;
  int d0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [IRQ_W-1:0] irq_pending = '0;
  logic [IRQ_W-1:0] irq_mask = '0;
  logic [NUM_KEYS-1:0] press = '0;
  logic sel_wr = 1'b0;
  logic sel_wdata = 1'b0;
  logic [1:0] pums = 2'h0;
  logic [1:0] mode_lvl = 2'h0;
  logic cs_drive = 1'b0;
  logic sclk_pin = 1'b0;
  logic mosi_pin = 1'b0;
  logic spi_miso_data = 1'b0;
  logic spi_miso_drive = 1'b0;
  logic i2c_sda_drive = 1'b0;
  logic sda_low = 1'b0;
  logic [1:0] usb_id_level = 2'h0;
  logic usb_src = 1'b0;
  logic [1:0] ts_mode = 2'h0;
  logic [2:0] adc_channel = 3'h0;
  logic general_output_four_sel = 1'b0;
  logic trig = 1'b0;
  wire logic [NUM_KEYS-1:0] turn_on_key_inputs;
  wire logic cs_pin, miso_pin_in, miso_pin_out, miso_pin_oe, alert, turn_on_event, sel_bit;
  wire logic power_on, charger_allowed, registers_to_default, mode_normal, mode_usb_lp_boot, mode_test;
  wire logic cs_pulldown_en, host_if_i2c, i2c_addr_a0, spi_cs, spi_sclk, spi_mosi, i2c_scl, i2c_sda_in;
  wire logic usb_id_floating, usb_id_grounded, usb_id_factory, usb_bus_power_switch;
  wire logic second_light_sensor_input, ts_x_bias_en, ts_y_ground_en, adc_start;
  wire logic [1:0] power_up_select;
  wire logic [3:0] ts_plate_to_adc;

  always #50 clk = ~clk;

  host_model host (.press, .cs_drive, .sda_low, .miso_pin_out, .miso_pin_oe,
    .keys(turn_on_key_inputs), .cs_pin, .miso_pin_in);

  pmic_control_pin_logic #(.GR_PRESENT(1'b1), .ACTIVE_LOW_SEL(1'b1), .HOLD_TICKS(P_HOLD),
    .SEQ_CYCLES(P_SEQ)) uut (.clk, .rst_n, .ce(1'b1), .irq_pending, .irq_mask, .alert,
    .turn_on_key_inputs, .turn_on_event, .global_reset_select_wr(sel_wr),
    .global_reset_select_wdata(sel_wdata), .global_reset_select_bit(sel_bit), .power_on,
    .charger_allowed, .registers_to_default, .power_up_select_pin_one(pums[0]),
    .power_up_select_pin_two(pums[1]), .mode_strap_level(mode_lvl), .power_up_select,
    .mode_normal, .mode_usb_lp_boot, .mode_test, .cs_pin, .sclk_pin, .mosi_pin, .miso_pin_in,
    .miso_pin_out, .miso_pin_oe, .cs_pulldown_en, .host_if_i2c, .i2c_addr_a0, .spi_miso_data,
    .spi_miso_drive, .i2c_sda_drive, .spi_cs, .spi_sclk, .spi_mosi, .i2c_scl, .i2c_sda_in,
    .usb_id_level, .usb_regulator_source_bit(usb_src), .usb_id_floating, .usb_id_grounded,
    .usb_id_factory, .usb_bus_power_switch, .ts_mode, .adc_channel, .general_output_four_adc_select(general_output_four_sel),
    .conversion_trigger_pin(trig), .ts_plate_to_adc, .second_light_sensor_input,
    .ts_x_bias_en, .ts_y_ground_en, .adc_start);

  // ----------------------------------------
  // Event counters and scoreboard
  // ----------------------------------------
  always @(posedge clk) if (turn_on_event === 1'b1) ev_count++;
  always @(negedge power_on) down_count++;

  function automatic logic [23:0] seen(int id);
    case (id)
      0: return alert;
      1: return {usb_id_factory, usb_id_grounded, usb_id_floating};
      2: return usb_bus_power_switch;
      3: return ts_plate_to_adc;
      4: return second_light_sensor_input;
      5: return {ts_x_bias_en, ts_y_ground_en};
      6: return adc_start;
      7: return sel_bit;
      8: return power_on;
      9: return charger_allowed;
      10: return registers_to_default;
      11: return ev_count;
      12: return down_count;
      13: return power_up_select;
      14: return {mode_normal, mode_usb_lp_boot, mode_test};
      15: return host_if_i2c;
      16: return i2c_addr_a0;
      17: return spi_cs;
      18: return i2c_scl;
      20: return {miso_pin_out, miso_pin_oe, spi_sclk, spi_mosi, i2c_sda_in};
      default: return cs_pulldown_en;
    endcase
  endfunction

  task automatic check(string nm, logic [23:0] got, logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic note(int id, string nm, logic [23:0] e);
    note_q.push_back('{id, nm, e});
  endtask

  initial forever
  begin
    wait (note_q.size() > 0);
    cur = note_q.pop_front();
    check(cur.name, seen(cur.id), cur.exp);
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic step();
    @(posedge clk);
    #DLY;
  endtask

  task automatic do_reset(input logic [1:0] md, input logic cs, input logic mo);
    logic [2:0] m_exp;
    rst_n = 1'b0;
    mode_lvl = md;
    cs_drive = cs;
    mosi_pin = mo;
    pums = 2'($urandom_range(3));
    m_exp = (md == STRAP_GND) ? 3'h4 : (md == STRAP_DIGCORE) ? 3'h2 : 3'h1;
    repeat (3) step();
    rst_n = 1'b1;
    step();
    note(7, "sel_bit", GR_SEL_RESET);
    note(13, "pus", pums);
    note(14, "modes", m_exp);
    note(15, "i2c_mode", cs);
    note(16, "a0", mo);
    note(19, "cs_pull", 1'b1);
  endtask

  task automatic hold_key(int k, int ticks);
    e0 = ev_count;
    d0 = down_count;
    press[k] = 1'b1;
    repeat (ticks * TICK_DIV) step();
    press[k] = 1'b0;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h4986));
    do_reset(STRAP_GND, 1'b0, 1'b0);
    cs_drive = 1'b1;
    step();
    note(17, "spi_cs", 1'b1);
    cs_drive = 1'b0;
    repeat (20)
    begin
      irq_pending = IRQ_W'($urandom);
      irq_mask = IRQ_W'($urandom) | IRQ_W'($urandom);
      {spi_miso_data, spi_miso_drive, i2c_sda_drive, sda_low, sclk_pin, mosi_pin} = 6'($urandom);
      step();
      note(0, "alert", |(irq_pending & ~irq_mask));
      note(20, "spi_pins", {spi_miso_data, spi_miso_drive, sclk_pin, mosi_pin, 1'b1});
    end
    for (int i = 0; i < 3; i++)
    begin
      usb_id_level = 2'(i);
      usb_src = i[0];
      step();
      note(1, "usb_id", 3'h1 << i);
      note(2, "usb_sw", i[0]);
    end
    for (int c = 0; c < 9; c++)
    begin
      adc_channel = (c == 8) ? 3'h7 : 3'(c);
      general_output_four_sel = (c == 8);
      step();
      note(3, "plates", (c >= 4 && c < 8) ? 4'h1 << (c - 4) : 4'h0);
      note(4, "light2", c == 8);
    end
    ts_mode = TS_INTERRUPT;
    general_output_four_sel = 1'b0;
    step();
    note(5, "bias", 2'h3);
    note(3, "plates", 4'h0);
    ts_mode = TS_INACTIVE;
    step();
    note(5, "bias", 2'h0);
    note(3, "plates", 4'h8);
    repeat (2)
    begin
      trig = 1'b1;
      repeat (2) step();
      note(6, "adc_start", 1'b0);
      step();
      note(6, "adc_start", 1'b1);
      step();
      note(6, "adc_start", 1'b0);
      trig = 1'b0;
      step();
    end
    for (int k = 0; k < NUM_KEYS; k++)
    begin
      hold_key(k, P_HOLD / 2);
      repeat (6 * TICK_DIV) step();
      note(11, "events", e0 + 1);
      note(12, "downs", d0);
    end
    hold_key(GR_KEY_IDX, P_HOLD + 10);
    pums = ~pums;
    for (int w = 0; w < 6 * TICK_DIV && power_on === 1'b1; w++) step();
    note(8, "power_on", 1'b0);
    note(9, "charger", 1'b0);
    repeat (P_SEQ) step();
    note(10, "to_default", 1'b1);
    step();
    note(8, "power_on", 1'b1);
    note(7, "sel_bit", GR_SEL_RESET);
    note(13, "pus", pums);
    repeat (P_SEQ) step();
    note(9, "charger", 1'b1);
    sel_wr = 1'b1;
    sel_wdata = 1'b1;
    step();
    sel_wr = 1'b0;
    note(7, "sel_bit", 1'b1);
    hold_key(GR_KEY_IDX, P_HOLD + 10);
    repeat (6 * TICK_DIV) step();
    note(12, "downs", d0);
    note(11, "events", e0 + 1);
    for (int m = 1; m < 3; m++)
    begin
      do_reset(2'(m), 1'b1, m[0]);
      sda_low = m[0];
      i2c_sda_drive = 1'b0;
      sclk_pin = 1'b0;
      step();
      note(17, "spi_cs", 1'b0);
      note(18, "scl", 1'b0);
      sclk_pin = 1'b1;
      step();
      note(18, "scl", 1'b1);
      note(20, "i2c_pins", {4'h0, !sda_low});
    end
    wait (note_q.size() == 0);
    #1;
    print_verdict();
  end
endmodule
